// *** hw/clock_output_consts.svh ***
// Offsets, field positions, reset values and step sizes for the output
// channel configuration bank. Definitions only.
`ifndef CLOCK_OUTPUT_CONSTS_SVH
`define CLOCK_OUTPUT_CONSTS_SVH

`define PAGE_SELECT_ADDR 8'hFF
`define OUTPUT_PAGE_NUMBER 8'h01
`define OUT0B_DIVIDER_MID_ADDR 8'h60
`define OUT0B_DELAY_SUPPLY_ADDR 8'h64
`define OUT0B_DRIVER_STANDARD_ADDR 8'h65
`define OUT0B_TERMINATION_MODE_ADDR 8'h67
`define OUT1B_DIVIDER_HIGH_ADDR 8'h68
`define OUT1B_DIVIDER_MID_ADDR 8'h69
`define OUT1B_DIVIDER_LOW_ADDR 8'h6A
`define OUT1B_PHASE_STRENGTH_ADDR 8'h6B

`define REG_RESET_VALUE 8'h00
`define UNMAPPED_READ_VALUE 8'h00

`define COARSE_DELAY_MSB 5
`define COARSE_DELAY_LSB 0
`define FINE_DELAY_MSB 7
`define FINE_DELAY_LSB 6
`define SUPPLY_SELECT_MSB 4
`define SUPPLY_SELECT_LSB 3
`define DRIVER_STANDARD_MSB 2
`define DRIVER_STANDARD_LSB 0
`define FINE_DELAY_EXT_BIT 4
`define DIVIDER_TOP_MSB 7
`define DIVIDER_TOP_LSB 6
`define TERMINATION_MSB 3
`define TERMINATION_LSB 0
`define DIVIDER_NIBBLE_MSB 3
`define DIVIDER_NIBBLE_LSB 0
`define PHASE_SELECT_MSB 7
`define PHASE_SELECT_LSB 6
`define SE_STRENGTH_MSB 2
`define SE_STRENGTH_LSB 0

`define FINE_STEP_PS 8'h1E
`define FINE_MAX_STEPS 3'h4
`define SE_STRENGTH_RECOMMENDED 3'h7

`endif

// *** hw/clock_output_pkg.sv ***
// Types shared by the output channel configuration bank and its decoder.
// Assumes the constants header supplies every numeric value.
package clock_output_pkg;

  typedef enum logic [1:0] {
    SUPPLY_1V8,
    SUPPLY_2V5,
    SUPPLY_3V3,
    SUPPLY_RESERVED
  } supply_t;

  typedef enum logic [2:0] {
    DRIVER_LVDS,
    DRIVER_LVPECL_CM,
    DRIVER_CML,
    DRIVER_HCSL,
    DRIVER_LVDS_BOOSTED,
    DRIVER_LVPECL_NO_CM,
    DRIVER_RESERVED6,
    DRIVER_RESERVED7
  } driver_t;

  typedef enum logic [2:0] {
    TERM_DIFF_EXTERNAL,
    TERM_DIFF_PULL_UP,
    TERM_DIFF_PULL_DOWN,
    TERM_CMOS_POSITIVE,
    TERM_CMOS_NEGATIVE,
    TERM_CMOS_BOTH,
    TERM_UNDEFINED
  } term_t;

  typedef enum logic {
    PHASE_TRUE,
    PHASE_COMPLEMENT
  } phase_t;

endpackage

// *** hw/output_mode_decode.sv ***
// Decodes a termination field and a single-ended phase select into pad
// behaviour. Purely combinational; inputs come from configuration flops.
`timescale 1ns/1ps
`include "clock_output_consts.svh"

module output_mode_decode (
  input wire logic [3:0] terminationCode, // Termination/single-ended field
  input wire logic [1:0] phaseSelect, // Single-ended phase select
  output clock_output_pkg::term_t terminationMode, // Decoded mode
  output logic differentialMode, // Pads run as a differential pair
  output logic positivePinDriveEn_n, // Low while positive pin drives CMOS
  output logic negativePinDriveEn_n, // Low while negative pin drives CMOS
  output clock_output_pkg::phase_t positivePadSource, // Phase on positive pad
  output clock_output_pkg::phase_t negativePadSource // Phase on negative pad
);

  always_comb
  begin
    case (terminationCode)
      4'h0: terminationMode = clock_output_pkg::TERM_DIFF_EXTERNAL;
      4'h2: terminationMode = clock_output_pkg::TERM_DIFF_PULL_UP;
      4'h1: terminationMode = clock_output_pkg::TERM_DIFF_PULL_DOWN;
      4'h4: terminationMode = clock_output_pkg::TERM_CMOS_POSITIVE;
      4'h8: terminationMode = clock_output_pkg::TERM_CMOS_NEGATIVE;
      4'hC: terminationMode = clock_output_pkg::TERM_CMOS_BOTH;
      default: terminationMode = clock_output_pkg::TERM_UNDEFINED;
    endcase
  end

  // Undefined codes park both pads idle rather than guess a standard
  always_comb
  begin
    differentialMode = 1'b0;
    positivePinDriveEn_n = 1'b1;
    negativePinDriveEn_n = 1'b1;
    case (terminationMode)
      clock_output_pkg::TERM_DIFF_EXTERNAL,
      clock_output_pkg::TERM_DIFF_PULL_UP,
      clock_output_pkg::TERM_DIFF_PULL_DOWN:
        differentialMode = 1'b1;
      clock_output_pkg::TERM_CMOS_POSITIVE:
        positivePinDriveEn_n = 1'b0;
      clock_output_pkg::TERM_CMOS_NEGATIVE:
        negativePinDriveEn_n = 1'b0;
      clock_output_pkg::TERM_CMOS_BOTH:
      begin
        positivePinDriveEn_n = 1'b0;
        negativePinDriveEn_n = 1'b0;
      end
      default:
        differentialMode = 1'b0;
    endcase
  end

  always_comb
  begin
    case (phaseSelect)
      2'h0:
      begin
        positivePadSource = clock_output_pkg::PHASE_TRUE;
        negativePadSource = clock_output_pkg::PHASE_COMPLEMENT;
      end
      2'h1:
      begin
        positivePadSource = clock_output_pkg::PHASE_TRUE;
        negativePadSource = clock_output_pkg::PHASE_TRUE;
      end
      default:
      begin
        positivePadSource = clock_output_pkg::PHASE_COMPLEMENT;
        negativePadSource = clock_output_pkg::PHASE_COMPLEMENT;
      end
    endcase
  end

endmodule

// *** hw/clock_output_channel_config.sv ***
// Paged configuration bank for output channels 0B and 1B.
// Assumes a byte-wide register port from the device's serial front end,
// on the same clock; page select sits at FFh on every page.
//
// What this block does
// - Channel 0B coarse delay is six-bit code times one VCO period, 0..63.
// - Delay byte bits 7:6 give zero to three 30 ps fine steps.
// - Driver register bit 4 extends fine code to three bits, 0..4 steps.
// - Supply select bits 4:3: 00 is 1.8 V, 01 2.5 V, 10 3.3 V.
// - Three-bit driver standard: LVDS, LVPECL, CML, HCSL, boosted LVDS, LVPECL2.
// - Driver register bits 7:6 supply channel 0B divider bits 25:24.
// - Termination value 0000 means differential with external termination.
// - 0010 is differential with pull-up; 0001 differential with pull-down.
// - 0100 CMOS on positive pin, 1000 on negative, 1100 on both.
// - Channel 1B divider bits 19:0 come from 68h nibble, 69h, 6Ah.
// - Phase select: 00 true/complement, 01 true on both, 1x complement both.
// - Writing FFh selects the page; FFh is readable and writable everywhere.
// - Register 60h supplies channel 0B divider bits 23:16.
`timescale 1ns/1ps
`include "clock_output_consts.svh"

module clock_output_channel_config (
  input wire logic clk, // 25 MHz clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [7:0] regAddr, // Register number within page
  input wire logic regWrite, // Write strobe, one cycle
  input wire logic [7:0] regWriteData, // Write data
  input wire logic regRead, // Read strobe, one cycle
  output logic [7:0] regReadData, // Read data, valid cycle after strobe
  output logic regReadValid, // Pulse with read data
  output logic [7:0] activePage, // Current page number
  output logic [5:0] out0bCoarseDelayCode, // VCO periods of coarse delay
  output logic [2:0] out0bFineDelayCode, // Three-bit fine delay code
  output logic [2:0] out0bFineDelaySteps, // Fine steps actually applied
  output logic [7:0] out0bFineDelayPs, // Fine delay in picoseconds
  output clock_output_pkg::supply_t out0bOutputSupplySelect, // Supply level
  output clock_output_pkg::driver_t out0bDriverStandardSelect, // Driver standard
  output logic out0bDriverStandardValid, // Code names a real standard
  output logic [9:0] out0bOutputDividerRatioTop, // Divider bits 25:16
  output clock_output_pkg::term_t out0bTerminationMode, // Decoded termination
  output logic out0bDifferentialMode, // Differential pair active
  output logic out0bPositivePinDriveEn_n, // Low while positive pin drives
  output logic out0bNegativePinDriveEn_n, // Low while negative pin drives
  output logic [19:0] out1bOutputDividerRatioLow, // Divider bits 19:0
  output clock_output_pkg::phase_t out1bPositivePadSource, // Positive pad phase
  output clock_output_pkg::phase_t out1bNegativePadSource, // Negative pad phase
  output logic [2:0] out1bSingleEndedStrength, // Single-ended drive strength
  output logic out1bStrengthRecommended // Strength equals recommended 7
);

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] out0bDividerMid;
    logic [7:0] out0bDelaySupply;
    logic [7:0] out0bDriverStandard;
    logic [7:0] out0bTerminationMode;
    logic [7:0] out1bDividerHigh;
    logic [7:0] out1bDividerMid;
    logic [7:0] out1bDividerLow;
    logic [7:0] out1bPhaseStrength;
    logic [7:0] readData;
    logic readValid;
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  logic onOutputPage;
  logic [7:0] readMux;
  logic [2:0] fineCode;

  // Page register answers on every page; bank registers only on their own
  function automatic logic bankHit(input logic [7:0] addr, input logic [7:0] target,
                                   input logic pageOk);
    bankHit = pageOk && (addr == target);
  endfunction

  assign onOutputPage = (state_ff.page == `OUTPUT_PAGE_NUMBER);

  always_comb
  begin
    readMux = `UNMAPPED_READ_VALUE;
    if (regAddr == `PAGE_SELECT_ADDR)
      readMux = state_ff.page;
    else if (bankHit(regAddr, `OUT0B_DIVIDER_MID_ADDR, onOutputPage))
      readMux = state_ff.out0bDividerMid;
    else if (bankHit(regAddr, `OUT0B_DELAY_SUPPLY_ADDR, onOutputPage))
      readMux = state_ff.out0bDelaySupply;
    else if (bankHit(regAddr, `OUT0B_DRIVER_STANDARD_ADDR, onOutputPage))
      readMux = state_ff.out0bDriverStandard;
    else if (bankHit(regAddr, `OUT0B_TERMINATION_MODE_ADDR, onOutputPage))
      readMux = state_ff.out0bTerminationMode;
    else if (bankHit(regAddr, `OUT1B_DIVIDER_HIGH_ADDR, onOutputPage))
      readMux = state_ff.out1bDividerHigh;
    else if (bankHit(regAddr, `OUT1B_DIVIDER_MID_ADDR, onOutputPage))
      readMux = state_ff.out1bDividerMid;
    else if (bankHit(regAddr, `OUT1B_DIVIDER_LOW_ADDR, onOutputPage))
      readMux = state_ff.out1bDividerLow;
    else if (bankHit(regAddr, `OUT1B_PHASE_STRENGTH_ADDR, onOutputPage))
      readMux = state_ff.out1bPhaseStrength;
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.readValid = regRead;
    if (regRead)
      nxt_state.readData = readMux;
    if (regWrite)
    begin
      if (regAddr == `PAGE_SELECT_ADDR)
        nxt_state.page = regWriteData;
      if (bankHit(regAddr, `OUT0B_DIVIDER_MID_ADDR, onOutputPage))
        nxt_state.out0bDividerMid = regWriteData;
      if (bankHit(regAddr, `OUT0B_DELAY_SUPPLY_ADDR, onOutputPage))
        nxt_state.out0bDelaySupply = regWriteData;
      if (bankHit(regAddr, `OUT0B_DRIVER_STANDARD_ADDR, onOutputPage))
        nxt_state.out0bDriverStandard = regWriteData;
      if (bankHit(regAddr, `OUT0B_TERMINATION_MODE_ADDR, onOutputPage))
        nxt_state.out0bTerminationMode = regWriteData;
      if (bankHit(regAddr, `OUT1B_DIVIDER_HIGH_ADDR, onOutputPage))
        nxt_state.out1bDividerHigh = regWriteData;
      if (bankHit(regAddr, `OUT1B_DIVIDER_MID_ADDR, onOutputPage))
        nxt_state.out1bDividerMid = regWriteData;
      if (bankHit(regAddr, `OUT1B_DIVIDER_LOW_ADDR, onOutputPage))
        nxt_state.out1bDividerLow = regWriteData;
      if (bankHit(regAddr, `OUT1B_PHASE_STRENGTH_ADDR, onOutputPage))
        nxt_state.out1bPhaseStrength = regWriteData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_ff.page <= `REG_RESET_VALUE;
      state_ff.out0bDividerMid <= `REG_RESET_VALUE;
      state_ff.out0bDelaySupply <= `REG_RESET_VALUE;
      state_ff.out0bDriverStandard <= `REG_RESET_VALUE;
      state_ff.out0bTerminationMode <= `REG_RESET_VALUE;
      state_ff.out1bDividerHigh <= `REG_RESET_VALUE;
      state_ff.out1bDividerMid <= `REG_RESET_VALUE;
      state_ff.out1bDividerLow <= `REG_RESET_VALUE;
      state_ff.out1bPhaseStrength <= `REG_RESET_VALUE;
      state_ff.readData <= `REG_RESET_VALUE;
      state_ff.readValid <= 1'b0;
    end
    else
      state_ff <= nxt_state;
  end

  assign regReadData = state_ff.readData;
  assign regReadValid = state_ff.readValid;
  assign activePage = state_ff.page;

  assign out0bCoarseDelayCode =
    state_ff.out0bDelaySupply[`COARSE_DELAY_MSB:`COARSE_DELAY_LSB];

  // The two delay-byte bits are the low part; bit 4 of the driver register tops it
  assign fineCode = {state_ff.out0bDriverStandard[`FINE_DELAY_EXT_BIT],
                     state_ff.out0bDelaySupply[`FINE_DELAY_MSB:`FINE_DELAY_LSB]};
  assign out0bFineDelayCode = fineCode;

  // Codes above four have no defined step count, so clamp at the largest one
  assign out0bFineDelaySteps = (fineCode > `FINE_MAX_STEPS) ? `FINE_MAX_STEPS : fineCode;

  always_comb
  begin
    out0bFineDelayPs = 8'h00;
    case (out0bFineDelaySteps)
      3'h1: out0bFineDelayPs = `FINE_STEP_PS;
      3'h2: out0bFineDelayPs = 8'(`FINE_STEP_PS * 2);
      3'h3: out0bFineDelayPs = 8'(`FINE_STEP_PS * 3);
      3'h4: out0bFineDelayPs = 8'(`FINE_STEP_PS * 4);
      default: out0bFineDelayPs = 8'h00;
    endcase
  end

  assign out0bOutputSupplySelect = clock_output_pkg::supply_t'(
    state_ff.out0bDelaySupply[`SUPPLY_SELECT_MSB:`SUPPLY_SELECT_LSB]);

  assign out0bDriverStandardSelect = clock_output_pkg::driver_t'(
    state_ff.out0bDriverStandard[`DRIVER_STANDARD_MSB:`DRIVER_STANDARD_LSB]);

  always_comb
  begin
    case (out0bDriverStandardSelect)
      clock_output_pkg::DRIVER_RESERVED6,
      clock_output_pkg::DRIVER_RESERVED7:
        out0bDriverStandardValid = 1'b0;
      default:
        out0bDriverStandardValid = 1'b1;
    endcase
  end

  assign out0bOutputDividerRatioTop = {
    state_ff.out0bDriverStandard[`DIVIDER_TOP_MSB:`DIVIDER_TOP_LSB],
    state_ff.out0bDividerMid};

  // Upper nibble of 68h is left out on purpose
  assign out1bOutputDividerRatioLow = {
    state_ff.out1bDividerHigh[`DIVIDER_NIBBLE_MSB:`DIVIDER_NIBBLE_LSB],
    state_ff.out1bDividerMid,
    state_ff.out1bDividerLow};

  assign out1bSingleEndedStrength =
    state_ff.out1bPhaseStrength[`SE_STRENGTH_MSB:`SE_STRENGTH_LSB];
  assign out1bStrengthRecommended = (out1bSingleEndedStrength == `SE_STRENGTH_RECOMMENDED);

  // Channel 0B supplies the termination decode; channel 1B supplies the phase select
  output_mode_decode modeDecode (
    .terminationCode(state_ff.out0bTerminationMode[`TERMINATION_MSB:`TERMINATION_LSB]),
    .phaseSelect(state_ff.out1bPhaseStrength[`PHASE_SELECT_MSB:`PHASE_SELECT_LSB]),
    .terminationMode(out0bTerminationMode),
    .differentialMode(out0bDifferentialMode),
    .positivePinDriveEn_n(out0bPositivePinDriveEn_n),
    .negativePinDriveEn_n(out0bNegativePinDriveEn_n),
    .positivePadSource(out1bPositivePadSource),
    .negativePadSource(out1bNegativePadSource)
  );

endmodule

// *** testbench/clock_output_channel_config_monitor.sv ***
// Checker for the output channel configuration bank, bound to its ports.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps
`include "clock_output_consts.svh"

module clock_output_channel_config_monitor (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic [7:0] regAddr, // Address
  input wire logic regWrite, // Write strobe
  input wire logic [7:0] regWriteData, // Write data
  input wire logic regRead, // Read strobe
  input wire logic regReadValid, // Read answer
  input wire logic [7:0] activePage, // Page
  input wire logic [5:0] out0bCoarseDelayCode, // Coarse code
  input wire logic [2:0] out0bFineDelayCode, // Fine code
  input wire logic [2:0] out0bFineDelaySteps, // Fine steps
  input wire logic [7:0] out0bFineDelayPs, // Fine ps
  input clock_output_pkg::driver_t out0bDriverStandardSelect, // Driver
  input wire logic out0bDriverStandardValid, // Driver valid
  input clock_output_pkg::term_t out0bTerminationMode, // Termination
  input wire logic out0bDifferentialMode, // Differential
  input wire logic out0bPositivePinDriveEn_n, // Positive pin
  input wire logic [19:0] out1bOutputDividerRatioLow, // Divider 1B
  input wire logic [2:0] out1bSingleEndedStrength // Strength
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_READ_ANSWER: assert property (regRead |=> regReadValid)
    else $error("read not answered");
  AST_VALID_PULSE: assert property (!regRead |=> !regReadValid)
    else $error("read valid without read");
  AST_PAGE_WRITE: assert property (regWrite && regAddr == `PAGE_SELECT_ADDR
    |=> activePage == $past(regWriteData))
    else $error("page write lost");
  AST_PAGE_HOLD: assert property (!(regWrite && regAddr == `PAGE_SELECT_ADDR) |=> $stable(activePage))
    else $error("page changed");
  // Off-page writes must not leak into the bank
  AST_OFF_PAGE: assert property (regWrite && activePage != `OUTPUT_PAGE_NUMBER
    |=> $stable(out1bOutputDividerRatioLow) && $stable(out0bCoarseDelayCode))
    else $error("off-page write took effect");
  AST_FINE_STEPS: assert property (out0bFineDelaySteps ==
    ((out0bFineDelayCode > 3'h4) ? 3'h4 : out0bFineDelayCode))
    else $error("fine steps wrong");
  AST_FINE_PS: assert property (out0bFineDelayPs == 8'(out0bFineDelaySteps) * `FINE_STEP_PS)
    else $error("fine ps wrong");
  AST_DRIVER_VALID: assert property (out0bDriverStandardValid == (out0bDriverStandardSelect <= 3'h5))
    else $error("driver valid wrong");
  AST_TERM_DIFF: assert property (out0bDifferentialMode == (out0bTerminationMode inside
    {clock_output_pkg::TERM_DIFF_EXTERNAL, clock_output_pkg::TERM_DIFF_PULL_UP,
    clock_output_pkg::TERM_DIFF_PULL_DOWN}))
    else $error("differential mode wrong");
  AST_POS_PIN: assert property (out0bPositivePinDriveEn_n == !(out0bTerminationMode inside
    {clock_output_pkg::TERM_CMOS_POSITIVE, clock_output_pkg::TERM_CMOS_BOTH}))
    else $error("positive pin enable wrong");
  AST_STRENGTH_WRITE: assert property (regWrite && regAddr == 8'h6B && activePage == `OUTPUT_PAGE_NUMBER
    |=> out1bSingleEndedStrength == $past(regWriteData[2:0]))
    else $error("strength not stored");

  cover property (regRead && regWrite);
  cover property (out0bFineDelayCode > 3'h4);
  cover property (out0bTerminationMode == clock_output_pkg::TERM_CMOS_BOTH);
endmodule

bind clock_output_channel_config clock_output_channel_config_monitor u_mon (.clk(clk), .reset_n(reset_n),
  .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
  .regReadValid(regReadValid), .activePage(activePage), .out0bCoarseDelayCode(out0bCoarseDelayCode),
  .out0bFineDelayCode(out0bFineDelayCode), .out0bFineDelaySteps(out0bFineDelaySteps),
  .out0bFineDelayPs(out0bFineDelayPs), .out0bDriverStandardSelect(out0bDriverStandardSelect),
  .out0bDriverStandardValid(out0bDriverStandardValid), .out0bTerminationMode(out0bTerminationMode),
  .out0bDifferentialMode(out0bDifferentialMode), .out0bPositivePinDriveEn_n(out0bPositivePinDriveEn_n),
  .out1bOutputDividerRatioLow(out1bOutputDividerRatioLow), .out1bSingleEndedStrength(out1bSingleEndedStrength));

// *** testbench/test_clock_output_channel_config.sv ***
// Self-checking bench for the output channel configuration bank.
// Assumes the bank alone, driven through its byte-wide register strobes.
`timescale 1ns/1ps
`include "clock_output_consts.svh"

module test_clock_output_channel_config;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regWrite = 1'b0;
  logic [7:0] regWriteData = 8'h00;
  logic regRead = 1'b0;
  logic [7:0] regReadData, activePage, out0bFineDelayPs;
  logic regReadValid, out0bDriverStandardValid, out0bDifferentialMode;
  logic out0bPositivePinDriveEn_n, out0bNegativePinDriveEn_n, out1bStrengthRecommended;
  logic [5:0] out0bCoarseDelayCode;
  logic [2:0] out0bFineDelayCode, out0bFineDelaySteps, out1bSingleEndedStrength;
  logic [9:0] out0bOutputDividerRatioTop;
  logic [19:0] out1bOutputDividerRatioLow;
  clock_output_pkg::supply_t out0bOutputSupplySelect;
  clock_output_pkg::driver_t out0bDriverStandardSelect;
  clock_output_pkg::term_t out0bTerminationMode;
  clock_output_pkg::phase_t out1bPositivePadSource, out1bNegativePadSource;
  logic [7:0] dly [4] = '{8'hC5, 8'h3F, 8'h10, 8'h08};
  logic [2:0] steps;
  logic [3:0] t;
  int fails = 0;
  int checked = 0;

  clock_output_channel_config u_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
    .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData), .regReadValid(regReadValid),
    .activePage(activePage), .out0bCoarseDelayCode(out0bCoarseDelayCode), .out0bFineDelayCode(out0bFineDelayCode),
    .out0bFineDelaySteps(out0bFineDelaySteps), .out0bFineDelayPs(out0bFineDelayPs),
    .out0bOutputSupplySelect(out0bOutputSupplySelect), .out0bDriverStandardSelect(out0bDriverStandardSelect),
    .out0bDriverStandardValid(out0bDriverStandardValid), .out0bOutputDividerRatioTop(out0bOutputDividerRatioTop),
    .out0bTerminationMode(out0bTerminationMode), .out0bDifferentialMode(out0bDifferentialMode),
    .out0bPositivePinDriveEn_n(out0bPositivePinDriveEn_n), .out0bNegativePinDriveEn_n(out0bNegativePinDriveEn_n),
    .out1bOutputDividerRatioLow(out1bOutputDividerRatioLow), .out1bPositivePadSource(out1bPositivePadSource),
    .out1bNegativePadSource(out1bNegativePadSource), .out1bSingleEndedStrength(out1bSingleEndedStrength),
    .out1bStrengthRecommended(out1bStrengthRecommended));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Idle cycle after each strobe so no signal is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrite = 1'b1;
    regAddr = a;
    regWriteData = d;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regRead = 1'b1;
    regAddr = a;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    chk("regReadValid", regReadValid, 20'h1);
    chk("regReadData", regReadData, exp);
    @(posedge clk);
    #1;
    chk("regReadValid", regReadValid, 20'h0);
  endtask

  task automatic wrap_up;
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic clock_output_pkg::term_t termOf(input logic [3:0] c);
    case (c)
      4'h0: return clock_output_pkg::TERM_DIFF_EXTERNAL;
      4'h2: return clock_output_pkg::TERM_DIFF_PULL_UP;
      4'h1: return clock_output_pkg::TERM_DIFF_PULL_DOWN;
      4'h4: return clock_output_pkg::TERM_CMOS_POSITIVE;
      4'h8: return clock_output_pkg::TERM_CMOS_NEGATIVE;
      4'hC: return clock_output_pkg::TERM_CMOS_BOTH;
      default: return clock_output_pkg::TERM_UNDEFINED;
    endcase
  endfunction

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk("activePage", activePage, 20'h0);
    chk("supply", out0bOutputSupplySelect, clock_output_pkg::SUPPLY_1V8);
    chk("driver", out0bDriverStandardSelect, clock_output_pkg::DRIVER_LVDS);
    chk("termination", out0bTerminationMode, clock_output_pkg::TERM_DIFF_EXTERNAL);
    wr(8'h64, 8'hFF);
    wr(8'hFF, `OUTPUT_PAGE_NUMBER);
    rd(8'hFF, `OUTPUT_PAGE_NUMBER);
    rd(8'h64, 8'h00);
    wr(8'h66, 8'h5A);
    rd(8'h66, 8'h00);
    foreach (dly[i])
    begin
      wr(8'h64, dly[i]);
      chk("coarse", out0bCoarseDelayCode, dly[i][5:0]);
      chk("supply", out0bOutputSupplySelect, dly[i][4:3]);
      rd(8'h64, dly[i]);
    end
    wr(8'h60, 8'hA5);
    for (int f = 0; f < 8; f++)
    begin
      wr(8'h64, {f[1:0], 6'h00});
      wr(8'h65, {f[1:0], 1'b0, f[2], 1'b0, f[2:0]});
      steps = (f > 4) ? 3'h4 : f[2:0];
      chk("fineCode", out0bFineDelayCode, f[2:0]);
      chk("fineSteps", out0bFineDelaySteps, steps);
      chk("finePs", out0bFineDelayPs, 8'(steps) * 8'h1E);
      chk("driver", out0bDriverStandardSelect, f[2:0]);
      chk("driverValid", out0bDriverStandardValid, f < 6);
      chk("dividerTop", out0bOutputDividerRatioTop, {f[1:0], 8'hA5});
    end
    for (int i = 0; i < 16; i++)
    begin
      t = i[3:0];
      wr(8'h67, {4'h0, t});
      chk("termination", out0bTerminationMode, termOf(t));
      chk("diffMode", out0bDifferentialMode, t inside {4'h0, 4'h1, 4'h2});
      chk("posDriveEn_n", out0bPositivePinDriveEn_n, !(t inside {4'h4, 4'hC}));
      chk("negDriveEn_n", out0bNegativePinDriveEn_n, !(t inside {4'h8, 4'hC}));
    end
    wr(8'h68, 8'hF3);
    wr(8'h69, 8'h5A);
    wr(8'h6A, 8'hC7);
    chk("dividerLow", out1bOutputDividerRatioLow, 20'h35AC7);
    rd(8'h68, 8'hF3);
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h6B, {p[1:0], 3'h0, 1'b1, p[1:0]});
      chk("posSource", out1bPositivePadSource, p > 1);
      chk("negSource", out1bNegativePadSource, p != 1);
      chk("strength", out1bSingleEndedStrength, {1'b1, p[1:0]});
      chk("strengthRec", out1bStrengthRecommended, p == 3);
    end
    // Read and write together: the read must see the old byte
    regRead = 1'b1;
    regWrite = 1'b1;
    regAddr = 8'h69;
    regWriteData = 8'h11;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    regWrite = 1'b0;
    chk("regReadData", regReadData, 20'h5A);
    @(posedge clk);
    #1;
    rd(8'h69, 8'h11);
    reset_n = 1'b0;
    @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk("activePage", activePage, 20'h0);
    chk("dividerLow", out1bOutputDividerRatioLow, 20'h0);
    wrap_up();
  end
endmodule
